// [hw/ccs_top.sv]
// Purpose: Cyclic conversion scheduler with period timer and cycle count.
// Assumes: Plain register port, read data one cycle after the read strobe.
// Notes:   Steps are timed here; the conversions themselves live elsewhere.
`timescale 1ns/10ps
module ccs_top
  import ccs_pkg::*;
#(
  parameter int NUM_STEPS = 4,
  parameter int COUNT_W   = 16,
  parameter int WIN_W     = 16
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  output logic [31:0]      rdata,
  output logic             active_flag,
  output logic             step_start,
  output logic [3:0]       step_index,
  output logic             step_done,
  output logic             meas_write,
  output logic             compare_strobe,
  output logic             balance_pause_select,
  output logic             balance_timer_pause_select
);

  initial begin
    if (NUM_STEPS < 1 || NUM_STEPS * CCS_PARAM_W > 32 || NUM_STEPS > 8)
      $error("ccs_top: NUM_STEPS unsupported");
    if (COUNT_W < 1 || COUNT_W > 16) $error("ccs_top: COUNT_W unsupported");
    if (WIN_W < 12) $error("ccs_top: WIN_W too small for the widest window");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Period parameter of one step from a packed set
  function automatic logic [CCS_PARAM_W-1:0] step_param(input logic [31:0] steps,
                                                        input logic [3:0]  idx);
    logic [31:0] sh;
    sh = steps >> (idx * CCS_PARAM_W);
    return sh[CCS_PARAM_W-1:0];
  endfunction

  // Step is due when its parameter is nonzero and divides the cycle count
  function automatic logic step_due(input logic [CCS_PARAM_W-1:0] p,
                                    input logic [COUNT_W-1:0]     n);
    logic [COUNT_W-1:0] r;
    r = '0;
    if (p != '0) begin
      r = n % COUNT_W'(p);
    end
    return (p != '0) && (r == '0);
  endfunction

  // Step window length, doubling per select code
  function automatic logic [WIN_W-1:0] win_cycles(input logic [CCS_CTRL_WIN_W-1:0] sel);
    logic [WIN_W-1:0] base;
    base = WIN_W'(CCS_WIN_BASE_CYC);
    return base << sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam logic [3:0] LAST_IDX  = 4'(NUM_STEPS);
  localparam logic [4:0] TICK_LAST = 5'(CCS_TICK_CYCLES - 1);

  ccs_state_t                 state_reg;
  ccs_state_t                 state_next;
  logic [31:0]                ctrl_reg;
  logic [31:0]                steps_reg;
  logic [31:0]                rdata_reg;
  logic [31:0]                rdata_next;
  logic [4:0]                 presc_reg;
  logic [4:0]                 presc_next;
  logic [CCS_CTRL_PER_W-1:0]  timer_reg;
  logic [CCS_CTRL_PER_W-1:0]  timer_next;
  logic [COUNT_W-1:0]         count_reg;
  logic [COUNT_W-1:0]         count_next;
  logic                       overrun_reg;
  logic                       overrun_next;
  logic [3:0]                 idx_reg;
  logic [3:0]                 idx_next;
  logic [3:0]                 stepidx_reg;
  logic [CCS_CTRL_WIN_W-1:0]  cfg_win_reg;
  logic                       cfg_cont_reg;
  logic                       cfg_wb_reg;
  logic                       cfg_bal_reg;
  logic                       cfg_btim_reg;
  logic [31:0]                cfg_steps_reg;
  logic                       load_cfg;
  logic                       restart;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and control fields
  wire                        wr_ctrl   = wr_strobe && (addr == CCS_ADDR_CTRL);
  wire                        wr_steps  = wr_strobe && (addr == CCS_ADDR_STEPS);
  wire                        run_bit   = ctrl_reg[CCS_CTRL_RUN];
  wire [CCS_CTRL_PER_W-1:0]   period    = ctrl_reg[CCS_CTRL_PER_LO +: CCS_CTRL_PER_W]; // RULE_05
  wire                        is_off    = (state_reg == CCS_ST_OFF);
  wire                        is_active = (state_reg == CCS_ST_ACTIVE);
  wire                        is_idle   = (state_reg == CCS_ST_IDLE);
  wire                        tick      = (presc_reg == TICK_LAST);

  // Step engine signals
  // Skipped steps still cost one cycle each, so the routine length depends only on
  // the snapshot and the cycle count, never on when the host wrote the registers
  wire                        step_busy;
  wire                        timer_done;
  wire [CCS_PARAM_W-1:0]      cur_param = step_param(cfg_steps_reg, idx_reg);
  wire                        in_range  = (idx_reg < LAST_IDX);
  wire                        cur_due   = in_range && step_due(cur_param, count_reg); // RULE_06
  wire                        go_step   = is_active && !step_busy && cur_due;
  wire                        skip_step = is_active && !step_busy && in_range && !cur_due;
  wire                        rout_end  = is_active && !step_busy && !in_range;
  wire [WIN_W-1:0]            win_len   = win_cycles(cfg_win_reg); // RULE_02

  // Period expiry only counts in normal mode; continuous ignores the timer
  // Limitation: a period of zero expires at the first tick, giving back-to-back routines
  wire                        expire    = !is_off && !cfg_cont_reg && tick &&
                                          ({1'b0, timer_reg} + 13'd1 >= {1'b0, period}); // RULE_19
  // An expiry seen mid-routine is remembered, so a routine longer than the period
  // restarts straight away instead of waiting for another full period
  wire                        pend      = overrun_reg || expire; // RULE_14

  ////////////////////////////////////////////////////////////////////////////
  // Scheduler next state
  always_comb begin
    state_next   = state_reg;
    count_next   = count_reg;
    overrun_next = overrun_reg;
    restart      = 1'b0;
    load_cfg     = 1'b0;
    case (state_reg)
      CCS_ST_OFF: begin
        // Continuous bit is sampled here on the rise of the run bit, and again at every routine restart
        if (run_bit) begin // RULE_17 RULE_18
          state_next = CCS_ST_ACTIVE; // RULE_10
          restart    = 1'b1;
          load_cfg   = 1'b1;
        end
      end
      CCS_ST_ACTIVE: begin
        // Expiry mid-routine counts now, restart waits for the routine end
        if (expire) begin
          count_next   = count_reg + 1'b1; // RULE_09
          overrun_next = 1'b1;
        end
        if (rout_end) begin
          overrun_next = 1'b0;
          if (cfg_cont_reg) begin
            if (run_bit) begin // RULE_20
              count_next = count_reg + 1'b1; // RULE_19
              restart    = 1'b1;
              load_cfg   = 1'b1; // RULE_21
            end else begin
              state_next = CCS_ST_OFF; // RULE_16
              count_next = '0;
            end
          end else if (!run_bit) begin
            // Pulses of the run bit during the active phase are never seen
            state_next = CCS_ST_OFF; // RULE_11 RULE_12
            count_next = '0;
          end else if (pend) begin
            restart  = 1'b1; // RULE_14
            load_cfg = 1'b1;
          end else begin
            state_next = CCS_ST_IDLE;
          end
        end
      end
      CCS_ST_IDLE: begin
        if (!run_bit) begin // RULE_20
          state_next = CCS_ST_OFF; // RULE_11
          count_next = '0;
        end else if (expire) begin
          state_next = CCS_ST_ACTIVE; // RULE_09
          count_next = count_reg + 1'b1;
          restart    = 1'b1;
          load_cfg   = 1'b1; // RULE_21
        end
      end
      default: begin
        state_next   = CCS_ST_OFF;
        count_next   = '0;
        overrun_next = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period timer: prescaler ticks, timer counts ticks in both normal-mode phases and stays at zero in continuous
  always_comb begin
    presc_next = presc_reg;
    timer_next = timer_reg;
    if (state_next == CCS_ST_OFF || (is_off && restart)) begin
      presc_next = '0; // RULE_10 RULE_11
      timer_next = '0;
    end else if (expire) begin
      presc_next = '0;
      timer_next = '0; // RULE_09
    end else if (cfg_cont_reg) begin
      presc_next = '0;
      timer_next = '0;
    end else if (tick) begin
      presc_next = '0;
      timer_next = timer_reg + 1'b1; // RULE_08
    end else begin
      presc_next = presc_reg + 1'b1;
    end
  end

  // Step index walks through enabled and skipped steps
  assign idx_next = restart ? 4'd0 : ((go_step || skip_step) ? idx_reg + 4'd1 : idx_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Register port and read mux
  assign rdata_next =
    !rd_strobe                ? 32'h0000_0000 :
    (addr == CCS_ADDR_CTRL)   ? ctrl_reg :
    (addr == CCS_ADDR_STEPS)  ? steps_reg :
    (addr == CCS_ADDR_STATUS) ? {28'h000_0000, overrun_reg, cfg_cont_reg && !is_off,
                                 !is_off, is_active} :
    (addr == CCS_ADDR_COUNT)  ? ({4'h0, timer_reg, 16'h0000} |
                                 {16'h0000, 16'(count_reg)}) :
                                32'h0000_0000;

  // Software registers; control writes take effect through the sampling points, except the period field, which expiry reads live at each tick
  // Status and count have no write path, so a write there simply falls through
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg  <= CCS_CTRL_RESET;
      steps_reg <= CCS_STEPS_RESET;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata & CCS_CTRL_MASK;
      end
      if (wr_steps) begin
        steps_reg <= wdata;
      end
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scheduler state and counters
  // The count only moves at expiry, routine end or a stop from idle; the phases in between leave it frozen
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg   <= CCS_ST_OFF; // RULE_22
      count_reg   <= '0;
      timer_reg   <= '0;
      presc_reg   <= '0;
      overrun_reg <= 1'b0;
      idx_reg     <= 4'd0;
    end else begin
      state_reg   <= state_next;
      count_reg   <= count_next;
      timer_reg   <= timer_next;
      presc_reg   <= presc_next;
      overrun_reg <= overrun_next;
      idx_reg     <= idx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration snapshot, taken once per cycle start
  // Costs a few flops, but a routine never mixes old and new settings when the
  // host rewrites the control register part way through a cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_win_reg   <= '0;
      cfg_cont_reg  <= 1'b0;
      cfg_wb_reg    <= 1'b0;
      cfg_bal_reg   <= 1'b0;
      cfg_btim_reg  <= 1'b0;
      cfg_steps_reg <= 32'h0000_0000;
    end else if (load_cfg) begin
      cfg_win_reg   <= ctrl_reg[CCS_CTRL_WIN_LO +: CCS_CTRL_WIN_W]; // RULE_21
      cfg_cont_reg  <= ctrl_reg[CCS_CTRL_CONT]; // RULE_17
      cfg_wb_reg    <= ctrl_reg[CCS_CTRL_WB];
      cfg_bal_reg   <= ctrl_reg[CCS_CTRL_BAL];
      cfg_btim_reg  <= ctrl_reg[CCS_CTRL_BTIM];
      cfg_steps_reg <= steps_reg;
    end
  end

  // Step index output held from the step start
  // Held, not pulsed, so a consumer can tag the result that arrives with step done
  always_ff @(posedge clock) begin
    if (rst) begin
      stepidx_reg <= 4'd0;
    end else if (go_step) begin
      stepidx_reg <= idx_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step window timer
  ccs_step_timer #(
    .WIDTH (WIN_W)
  ) u_step_timer (
    .clock  (clock),
    .rst    (rst),
    .start  (go_step),
    .length (win_len),
    .busy   (step_busy),
    .done   (timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata                      = rdata_reg;
  assign active_flag                = is_active; // RULE_13
  assign step_start                 = go_step;
  assign step_index                 = stepidx_reg;
  assign step_done                  = timer_done;
  // Every completed step feeds the threshold compare, whatever the writeback choice
  assign compare_strobe             = timer_done; // RULE_03
  // Without writeback the result is compared and dropped
  assign meas_write                 = timer_done && cfg_wb_reg; // RULE_03 RULE_04
  assign balance_pause_select       = cfg_bal_reg;
  assign balance_timer_pause_select = cfg_btim_reg;

endmodule

// [hw/ccs_pkg.sv]
// Purpose: Constants for the cyclic conversion scheduler.
// Assumes: 20 MHz clock, byte addresses on the register port.
// Notes:   The register port carries one 32-bit word per register.
//
// Contract
// RULE_01: Host sets the periodic run bit to one to begin cycles.
// RULE_02: Step window select fixes each step's duration in cyclic execution.
// RULE_03: Writeback select zero: results only feed comparisons, no measurement write.
// RULE_04: Writeback select one: measurement written at each step completion.
// RULE_05: Period timer field in the control register sets the cycle period.
// RULE_06: A step runs only when its period parameter is nonzero.
// RULE_07: Host changes timer and count settings only with the run bit cleared.
// RULE_08: Cycle count frozen, period timer counting, in active and idle phase.
// RULE_09: Timer expiry adds one to count, restarts timer and routine.
// RULE_10: Run bit rise keeps count, restarts timer from zero, starts routine.
// RULE_11: Normal mode run bit fall: wait active end, then stop, reset counters.
// RULE_12: Normal mode ignores a set-clear pulse of the run bit while active.
// RULE_13: Active flag high while steps run, low during idle time.
// RULE_14: Routine longer than the period behaves as continuous mode.
// RULE_15: Host sets continuous bit before setting the run bit.
// RULE_16: Continuous mode run bit fall: stop after the last enabled step.
// RULE_17: Run bit rise starts periodic or continuous execution per continuous bit.
// RULE_18: Continuous bit changes while disabled have no effect.
// RULE_19: Continuous mode ignores timer, repeats routine, counts each completion.
// RULE_20: Run bit sampled continuously while idle, or per routine in continuous.
// RULE_21: Configuration applied once per period, or once per routine in continuous.
// RULE_22: After reset execution off, counters zero, active flag low.
package ccs_pkg;

  // Register byte offsets
  localparam logic [3:0] CCS_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] CCS_ADDR_STEPS  = 4'h4;
  localparam logic [3:0] CCS_ADDR_STATUS = 4'h8;
  localparam logic [3:0] CCS_ADDR_COUNT  = 4'hc;

  // Control register fields
  localparam int CCS_CTRL_RUN      = 0;
  localparam int CCS_CTRL_CONT     = 1;
  localparam int CCS_CTRL_WB       = 2;
  localparam int CCS_CTRL_BAL      = 3;
  localparam int CCS_CTRL_BTIM     = 4;
  localparam int CCS_CTRL_WIN_LO   = 8;
  localparam int CCS_CTRL_WIN_W    = 3;
  localparam int CCS_CTRL_PER_LO   = 16;
  localparam int CCS_CTRL_PER_W    = 12;
  localparam logic [31:0] CCS_CTRL_MASK  = 32'h0fff_071f;
  localparam logic [31:0] CCS_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CCS_STEPS_RESET = 32'h0000_0000;

  // Status register fields
  localparam int CCS_STAT_ACTIVE  = 0;
  localparam int CCS_STAT_ENABLED = 1;
  localparam int CCS_STAT_CONT    = 2;
  localparam int CCS_STAT_OVERRUN = 3;

  // Count register fields
  localparam int CCS_CNT_TIMER_LO = 16;

  // Step period parameter width per step
  localparam int CCS_PARAM_W = 4;

  // Timing: period timer tick and base step window
  localparam int CCS_CLK_NS       = 50;
  localparam int CCS_TICK_NS      = 1000;
  localparam int CCS_TICK_CYCLES  = (CCS_TICK_NS + CCS_CLK_NS - 1) / CCS_CLK_NS;
  localparam int CCS_WIN_BASE_NS  = 1000;
  localparam int CCS_WIN_BASE_CYC = (CCS_WIN_BASE_NS + CCS_CLK_NS - 1) / CCS_CLK_NS;

  // Scheduler states, one-hot
  typedef enum logic [2:0] {
    CCS_ST_OFF    = 3'b001,
    CCS_ST_ACTIVE = 3'b010,
    CCS_ST_IDLE   = 3'b100
  } ccs_state_t;

endpackage

// [hw/ccs_step_timer.sv]
// Purpose: Down counter timing one routine step window.
// Assumes: start is a one-cycle pulse, only given while not busy.
// Notes:   done pulses in the cycle busy falls.
`timescale 1ns/10ps
module ccs_step_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] length,
  output logic                  busy,
  output logic                  done
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic             done_reg;
  logic             done_next;

  initial begin
    if (WIDTH < 2) $error("ccs_step_timer: WIDTH too small");
  end

  // Load on start, count down to zero otherwise
  assign cnt_next  = start ? length : ((cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg);
  assign done_next = (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1}) && !start;

  ////////////////////////////////////////////////////////////////////////////
  // Counter state
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  // Busy covers the last count too, so a new start never lands on the cycle
  // that launches done; a start there would swallow the pending done pulse
  assign busy = (cnt_reg != '0);
  assign done = done_reg;

endmodule

// [testbench/ccs_checker.sv]
// Purpose: Port-level checks for the cyclic conversion scheduler.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes:   Window checks use 8 cycles, well under the shortest step window.
`timescale 1ns/10ps
module ccs_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        rd_strobe,
  input wire logic [31:0] rdata,
  input wire logic        active_flag,
  input wire logic        step_start,
  input wire logic [3:0]  step_index,
  input wire logic        step_done,
  input wire logic        meas_write,
  input wire logic        compare_strobe
);
  ////////////////////////////////////////////////////////////////////////////////
  // One clock and one reset, so clocking and disable are declared once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Step timing and result handling
  a_done_pulse_once: assert property (step_done |=> !step_done)
    else $error("step done held longer than one cycle");
  a_window_min_len: assert property (step_start |=> !step_done [*8])
    else $error("step window ended too early");
  a_start_spacing: assert property (step_start |=> !step_start [*8])
    else $error("steps overlap");
  a_meas_on_done: assert property (meas_write |-> step_done)
    else $error("measurement write outside step completion");
  a_cmp_with_done: assert property (compare_strobe == step_done)
    else $error("compare strobe not tied to step completion");
  a_start_in_active: assert property (step_start |-> active_flag)
    else $error("step started outside active phase");
  a_index_hold: assert property (!step_start |=> $stable(step_index))
    else $error("step index moved without a step start");

  ////////////////////////////////////////////////////////////////////////////////
  // Register port and reset state
  a_rdata_idle: assert property (!$past(rd_strobe) |-> rdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  a_reset_quiet: assert property ($fell(rst) |-> !active_flag && rdata == 32'h0000_0000)
    else $error("outputs not quiet after reset");
endmodule

bind ccs_top ccs_checker u_ccs_checker (
  .clock(clock), .rst(rst), .rd_strobe(rd_strobe), .rdata(rdata),
  .active_flag(active_flag), .step_start(step_start), .step_index(step_index),
  .step_done(step_done), .meas_write(meas_write), .compare_strobe(compare_strobe)
);

// [testbench/ccs_host_model.sv]
// Purpose: Host software model driving the register port.
// Assumes: Strobes one cycle, read data only in the cycle after the read.
// Notes:   Tasks are called hierarchically from the testbench.
`timescale 1ns/10ps
module ccs_host_model (
  input  wire logic        clock,
  output logic [3:0]       addr,
  output logic [31:0]      wdata,
  output logic             wr_strobe,
  output logic             rd_strobe,
  input  wire logic [31:0] rdata
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    addr      = 4'h0;
    wdata     = 32'h0000_0000;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
  end

  // One-cycle write; the caller keeps timer and count fields fixed while running
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr      <= a;
    wdata     <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
    wdata     <= ~d; // Stale data must not look valid
  endtask

  // One-cycle read; data taken mid-cycle so the answer has settled
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr      <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask
endmodule

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the cyclic conversion scheduler.
// Assumes: 50 ns clock, step window 20 cycles, tick 20 cycles.
// Notes:   Expectations come from the register map and period figures.
`timescale 1ns/10ps
module tb_top;
  import ccs_pkg::*;
  logic        clock;
  logic        rst;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr_strobe;
  logic        rd_strobe;
  logic [31:0] rdata;
  logic        active_flag;
  logic        step_start;
  logic [3:0]  step_index;
  logic        step_done;
  logic        meas_write;
  logic        compare_strobe;
  logic        bal_pause;
  logic        bal_tpause;
  int          err_count;
  int          checked;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and host model
  ccs_top u_ccs_top (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata), .active_flag(active_flag),
    .step_start(step_start), .step_index(step_index), .step_done(step_done),
    .meas_write(meas_write), .compare_strobe(compare_strobe),
    .balance_pause_select(bal_pause), .balance_timer_pause_select(bal_tpause)
  );
  ccs_host_model u_ccs_host_model (
    .clock(clock), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata)
  );

  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bounded waits
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Wait for the active flag to reach a level; a hang ends the run
  task automatic wait_act(input logic lvl, input int lim);
    int k;
    for (k = 0; k < lim && active_flag !== lvl; k++) @(negedge clock);
    if (active_flag !== lvl) begin
      err_count++;
      print_verdict();
    end
  endtask

  // Follow one active phase, counting starts, writes and compares
  task automatic run_cycle(output int ns, output int nm, output int nc);
    int k;
    ns = 0;
    nm = 0;
    nc = 0;
    wait_act(1'b1, 200);
    for (k = 0; k < 2000; k++) begin
      if (step_start === 1'b1) ns++;
      if (meas_write === 1'b1) nm++;
      if (compare_strobe === 1'b1) nc++;
      if (active_flag !== 1'b1) break;
      @(negedge clock);
    end
    if (active_flag === 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset();
    logic [31:0] d;
    check({31'h0, active_flag}, 32'h0000_0000);
    u_ccs_host_model.rd(CCS_ADDR_CTRL, d);
    check(d, CCS_CTRL_RESET);
    u_ccs_host_model.rd(CCS_ADDR_COUNT, d);
    check(d, 32'h0000_0000);
    u_ccs_host_model.wr(CCS_ADDR_STATUS, 32'hffff_ffff);
    u_ccs_host_model.wr(CCS_ADDR_CTRL, 32'h0000_0002);
    repeat (60) @(negedge clock);
    check({31'h0, active_flag}, 32'h0000_0000);
    u_ccs_host_model.rd(CCS_ADDR_STATUS, d);
    check(d, 32'h0000_0000);
    u_ccs_host_model.rd(4'h1, d);
    check(d, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic test_normal();
    logic [31:0] c1;
    logic [31:0] c2;
    int ns, nm, nc;
    u_ccs_host_model.wr(CCS_ADDR_STEPS, 32'h0000_0101);
    u_ccs_host_model.wr(CCS_ADDR_CTRL, 32'h0005_0005);
    run_cycle(ns, nm, nc);
    check(ns, 2);
    check(nm, 2);
    check({28'h000_0000, step_index}, 32'h0000_0002);
    check({30'h0, bal_pause, bal_tpause}, 32'h0000_0000);
    u_ccs_host_model.rd(CCS_ADDR_COUNT, c1);
    check(c1[15:0], 16'h0000);
    repeat (25) @(negedge clock);
    u_ccs_host_model.rd(CCS_ADDR_COUNT, c2);
    check(c2[15:0], c1[15:0]);
    check({31'h0, c2[27:16] == c1[27:16]}, 32'h0000_0000);
    u_ccs_host_model.wr(CCS_ADDR_CTRL, 32'h0005_0001);
    run_cycle(ns, nm, nc);
    check(nm, 0);
    check(nc, 2);
    u_ccs_host_model.rd(CCS_ADDR_COUNT, c1);
    check(c1[15:0], 16'h0001);
    wait_act(1'b1, 200);
    u_ccs_host_model.wr(CCS_ADDR_CTRL, 32'h0005_0000);
    @(negedge clock);
    check({31'h0, active_flag}, 32'h0000_0001);
    wait_act(1'b0, 100);
    u_ccs_host_model.rd(CCS_ADDR_COUNT, c1);
    check(c1, 32'h0000_0000);
    repeat (150) @(negedge clock);
    check({31'h0, active_flag}, 32'h0000_0000);
    $display("test normal done");
  endtask

  task automatic test_continuous();
    logic [31:0] c1;
    u_ccs_host_model.wr(CCS_ADDR_CTRL, 32'h0064_0002);
    u_ccs_host_model.wr(CCS_ADDR_CTRL, 32'h0064_001b);
    wait_act(1'b1, 20);
    check({30'h0, bal_pause, bal_tpause}, 32'h0000_0003);
    repeat (70) @(negedge clock);
    u_ccs_host_model.rd(CCS_ADDR_COUNT, c1);
    check(c1[15:0], 16'h0001);
    u_ccs_host_model.wr(CCS_ADDR_CTRL, 32'h0064_0002);
    wait_act(1'b0, 100);
    u_ccs_host_model.rd(CCS_ADDR_COUNT, c1);
    check(c1, 32'h0000_0000);
    repeat (80) @(negedge clock);
    check({31'h0, active_flag}, 32'h0000_0000);
    $display("test continuous done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 4 cycles, then the scenarios
  initial begin
    err_count = 0;
    checked   = 0;
    rst       = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    test_reset();
    test_normal();
    test_continuous();
    print_verdict();
  end
endmodule
